// *** rtl/sfmc_pkg.sv ***
// Package for the switch forwarding-mode configuration block.
// Assumes a config-space style register port driven by the core clock.
package sfmc_pkg;
  localparam logic [7:0]  OFS_MODE      = 8'h74;
  localparam logic [7:0]  OFS_PHY2      = 8'h78;
  localparam int          BIT_STORE_FWD = 0;
  localparam int          BIT_THR_LO    = 1;
  localparam int          BIT_ARB_HOLD  = 3;
  localparam int          BIT_CRD_ALL   = 4;
  localparam int          BIT_ORD_EGR   = 5;
  localparam int          BIT_ORD_TAG   = 6;
  localparam int          BIT_PM_LO     = 8;
  localparam int          BIT_POLINV    = 14;
  // Writable bits by software on each port flavour
  localparam logic [31:0] UP_RW_MASK    = 32'h0000_3F7F;
  localparam logic [31:0] DN_RW_MASK    = 32'h0000_3F00;
  // Bits that exist at all (loader may set these)
  localparam logic [31:0] UP_IMPL_MASK  = 32'h7FFF_FF7F;
  localparam logic [31:0] DN_IMPL_MASK  = 32'h7FFF_FF00;
  localparam logic [31:0] UP_RESET      = 32'h0A73_0102;
  localparam logic [31:0] DN_RESET      = 32'h0A73_0100;
  localparam logic [15:0] PHY2_RESET    = 16'h0080;
  localparam logic [1:0]  THR_RESET     = 2'h1;
  localparam logic [3:0]  MAX_BE        = 4'hF;
endpackage : sfmc_pkg

// *** rtl/sfmc_sync.sv ***
// Two-flop synchroniser for a level from outside the clock domain.
// No reset: the pair fills with the pin level while the block is in reset.
`timescale 1ns/1ps
module sfmc_sync (
  input  wire logic clk_sys,
  input  wire logic d,
  output logic      q
);
  logic meta;
  logic next_meta;
  logic next_q;
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end
  always_ff @(posedge clk_sys) begin
    meta <= next_meta;
    q    <= next_q;
  end
endmodule : sfmc_sync

// *** rtl/sfmc_top.sv ***
// Forwarding-mode config register; mode outputs except rx_pol_inv_dis are boundary-applied.
// Assumes config access and loader writes are one-cycle strobes on clk_sys.
// Notes on behaviour
// RULE1: Bit0 set selects store-forward, else cut-through
// RULE2: Threshold code moves start earlier from midpoint
// RULE3: Bit3 set holds grant on pending port
// RULE4: Bit3 clear grants only credit-ready requesters
// RULE5: Bit4 set releases all credit types together
// RULE6: Bit5 set orders across egress ports
// RULE7: Bit6 set orders completions with different tags
// RULE8: SMBus/EEPROM loader can replace reset defaults
// RULE9: Downstream polarity bit resets from strap pin
// RULE10: Downstream copy has no forwarding bits
// RULE11: Reserved zero; read-only ignores config writes
// RULE12: Mode changes apply only at packet boundaries, except polarity bit 14
`timescale 1ns/1ps
module sfmc_top #(
  parameter bit IS_DOWNSTREAM = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic        ld_wr,
  input  wire logic [7:0]  ld_addr,
  input  wire logic [31:0] ld_wdata,
  input  wire logic        rx_polarity_flip_off_strap,
  input  wire logic        pkt_boundary,
  output logic             store_fwd_mode,
  output logic [1:0]       cut_thr_code,
  output logic             arb_hold_mode,
  output logic             credit_all_types,
  output logic             order_egress,
  output logic             order_tag,
  output logic [5:0]       pm_param,
  output logic             rx_pol_inv_dis
);
  localparam logic [31:0] RW_MASK =
    IS_DOWNSTREAM ? sfmc_pkg::DN_RW_MASK : sfmc_pkg::UP_RW_MASK;
  localparam logic [31:0] IMPL_MASK =
    IS_DOWNSTREAM ? sfmc_pkg::DN_IMPL_MASK : sfmc_pkg::UP_IMPL_MASK;
  localparam logic [31:0] RST_VAL =
    IS_DOWNSTREAM ? sfmc_pkg::DN_RESET : sfmc_pkg::UP_RESET;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  logic        strap_s;
  logic        strap_done;
  logic [31:0] mode;
  logic [15:0] phy2;
  logic [31:0] next_mode;
  logic [15:0] next_phy2;
  logic        next_strap_done;
  logic [31:0] next_rdata;
  logic        next_rvalid;
  logic [31:0] applied;
  logic [31:0] next_applied;

  sfmc_sync u_strap (
    .clk_sys (clk_sys),
    .d       (rx_polarity_flip_off_strap),
    .q       (strap_s)
  );

  always_comb begin
    logic [31:0] wm;
    wm              = '0;
    next_mode       = mode;
    next_phy2       = phy2;
    next_strap_done = 1'b1;
    // Strap caught once after reset release, loader may still override
    if (IS_DOWNSTREAM && !strap_done) begin
      next_mode[sfmc_pkg::BIT_POLINV] = strap_s; // RULE9
    end
    if (cfg_wr && cfg_addr == sfmc_pkg::OFS_MODE) begin
      wm        = be_mask(cfg_be) & RW_MASK; // RULE11
      next_mode = (next_mode & ~wm) | (cfg_wdata & wm); // RULE10
    end
    // Loader has priority over a same-cycle config write
    if (ld_wr && ld_addr == sfmc_pkg::OFS_MODE) begin
      next_mode = ld_wdata & IMPL_MASK; // RULE8
    end
    if (ld_wr && ld_addr == sfmc_pkg::OFS_PHY2) begin
      next_phy2 = ld_wdata[15:0]; // RULE8
    end
  end

  always_comb begin
    next_rvalid = cfg_rd;
    next_rdata  = '0;
    if (cfg_rd) begin
      unique case (cfg_addr)
        sfmc_pkg::OFS_MODE: next_rdata = mode & IMPL_MASK; // RULE11
        sfmc_pkg::OFS_PHY2: next_rdata = {16'h0000, phy2};
        default:            next_rdata = '0;
      endcase
    end
  end

  always_comb begin
    next_applied = applied;
    if (pkt_boundary) begin
      next_applied = mode & IMPL_MASK; // RULE12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode       <= RST_VAL;
      phy2       <= sfmc_pkg::PHY2_RESET;
      strap_done <= 1'b0;
      cfg_rdata  <= '0;
      cfg_rvalid <= 1'b0;
      applied    <= RST_VAL & IMPL_MASK;
    end else begin
      mode       <= next_mode;
      phy2       <= next_phy2;
      strap_done <= next_strap_done;
      cfg_rdata  <= next_rdata;
      cfg_rvalid <= next_rvalid;
      applied    <= next_applied;
    end
  end

  // Mode outputs from the boundary-applied copy; rx_pol_inv_dis straight from mode
  always_comb begin
    store_fwd_mode   = applied[sfmc_pkg::BIT_STORE_FWD]; // RULE1
    cut_thr_code     = applied[sfmc_pkg::BIT_THR_LO +: 2]; // RULE2
    arb_hold_mode    = applied[sfmc_pkg::BIT_ARB_HOLD]; // RULE3 RULE4
    credit_all_types = applied[sfmc_pkg::BIT_CRD_ALL]; // RULE5
    order_egress     = applied[sfmc_pkg::BIT_ORD_EGR]; // RULE6
    order_tag        = applied[sfmc_pkg::BIT_ORD_TAG]; // RULE7
    pm_param         = applied[sfmc_pkg::BIT_PM_LO +: 6];
    rx_pol_inv_dis   = mode[sfmc_pkg::BIT_POLINV];
  end

  logic past_valid;
  always_ff @(posedge clk_sys) begin
    if (rst) past_valid <= 1'b0;
    else     past_valid <= 1'b1;
  end

  property p_applied_hold;
    @(posedge clk_sys) disable iff (rst)
      past_valid && !$past(pkt_boundary) |-> $stable(applied);
  endproperty
  a_applied_hold: assert property (p_applied_hold) // RULE12
    else $error("mode changed off a packet boundary");

  property p_applied_take;
    @(posedge clk_sys) disable iff (rst)
      pkt_boundary |=> applied == ($past(mode) & IMPL_MASK);
  endproperty
  a_applied_take: assert property (p_applied_take) // RULE12
    else $error("boundary did not apply mode");

  property p_store_fwd;
    @(posedge clk_sys) disable iff (rst)
      pkt_boundary |=>
        store_fwd_mode == $past(mode[sfmc_pkg::BIT_STORE_FWD]);
  endproperty
  a_store_fwd: assert property (p_store_fwd) // RULE1
    else $error("store-forward output mismatch");

  property p_thr;
    @(posedge clk_sys) disable iff (rst)
      pkt_boundary |=>
        cut_thr_code == $past(mode[sfmc_pkg::BIT_THR_LO +: 2]);
  endproperty
  a_thr: assert property (p_thr) // RULE2
    else $error("threshold output mismatch");

  property p_arb;
    @(posedge clk_sys) disable iff (rst)
      pkt_boundary |=>
        arb_hold_mode == $past(mode[sfmc_pkg::BIT_ARB_HOLD]);
  endproperty
  a_arb: assert property (p_arb) // RULE3 RULE4
    else $error("arbitration mode mismatch");

  property p_crd_ord;
    @(posedge clk_sys) disable iff (rst)
      pkt_boundary |=>
        {credit_all_types, order_egress, order_tag} ==
          {$past(mode[sfmc_pkg::BIT_CRD_ALL]),
           $past(mode[sfmc_pkg::BIT_ORD_EGR]),
           $past(mode[sfmc_pkg::BIT_ORD_TAG])};
  endproperty
  a_crd_ord: assert property (p_crd_ord) // RULE5 RULE6 RULE7
    else $error("credit or ordering output mismatch");

  property p_rsvd;
    @(posedge clk_sys) disable iff (rst)
      cfg_rvalid && $past(cfg_addr) == sfmc_pkg::OFS_MODE |->
        (cfg_rdata & ~IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE11
    else $error("reserved bits read nonzero");

  property p_ro_write;
    @(posedge clk_sys) disable iff (rst)
      cfg_wr && !ld_wr && strap_done |=>
        ((mode ^ $past(mode)) & ~RW_MASK) == 32'h0000_0000;
  endproperty
  a_ro_write: assert property (p_ro_write) // RULE11
    else $error("config write changed read-only bit");

  property p_loader;
    @(posedge clk_sys) disable iff (rst)
      ld_wr && ld_addr == sfmc_pkg::OFS_MODE |=>
        mode == ($past(ld_wdata) & IMPL_MASK);
  endproperty
  a_loader: assert property (p_loader) // RULE8
    else $error("loader value not taken");

  property p_dn_nofwd;
    @(posedge clk_sys) disable iff (rst)
      IS_DOWNSTREAM |-> mode[7:0] == 8'h00;
  endproperty
  a_dn_nofwd: assert property (p_dn_nofwd) // RULE10
    else $error("downstream forwarding bits set");

  property p_strap_take;
    @(posedge clk_sys) disable iff (rst)
      IS_DOWNSTREAM && !strap_done &&
        !(ld_wr && ld_addr == sfmc_pkg::OFS_MODE) |=>
          mode[sfmc_pkg::BIT_POLINV] == $past(strap_s);
  endproperty
  a_strap_take: assert property (p_strap_take) // RULE9
    else $error("strap level not taken into polarity bit");

  property p_dn_outputs;
    @(posedge clk_sys) disable iff (rst)
      IS_DOWNSTREAM |-> {order_tag, order_egress, credit_all_types,
        arb_hold_mode, cut_thr_code, store_fwd_mode} == 7'h00;
  endproperty
  a_dn_outputs: assert property (p_dn_outputs) // RULE10
    else $error("downstream forwarding output set");

  property p_phy2_ro;
    @(posedge clk_sys) disable iff (rst)
      cfg_wr && !(ld_wr && ld_addr == sfmc_pkg::OFS_PHY2) |=>
        $stable(phy2);
  endproperty
  a_phy2_ro: assert property (p_phy2_ro) // RULE11
    else $error("config write changed phy csr");

  property p_phy2_load;
    @(posedge clk_sys) disable iff (rst)
      ld_wr && ld_addr == sfmc_pkg::OFS_PHY2 |=>
        {16'h0000, phy2} == ($past(ld_wdata) & 32'h0000_FFFF);
  endproperty
  a_phy2_load: assert property (p_phy2_load) // RULE8
    else $error("loader value not taken into phy csr");

  property p_mode_idle;
    @(posedge clk_sys) disable iff (rst)
      !cfg_wr && !ld_wr && strap_done |=> $stable(mode);
  endproperty
  a_mode_idle: assert property (p_mode_idle) // RULE11
    else $error("mode register changed without a write");

  property p_mode_read;
    @(posedge clk_sys) disable iff (rst)
      cfg_rvalid && $past(cfg_addr) == sfmc_pkg::OFS_MODE |->
        cfg_rdata == ($past(mode) & IMPL_MASK);
  endproperty
  a_mode_read: assert property (p_mode_read) // RULE11
    else $error("mode read data mismatch");

  property p_phy2_read;
    @(posedge clk_sys) disable iff (rst)
      cfg_rvalid && $past(cfg_addr) == sfmc_pkg::OFS_PHY2 |->
        cfg_rdata == {16'h0000, $past(phy2)};
  endproperty
  a_phy2_read: assert property (p_phy2_read) // RULE11
    else $error("phy csr read data mismatch");

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (rst)
      cfg_rvalid && $past(cfg_addr) != sfmc_pkg::OFS_MODE &&
        $past(cfg_addr) != sfmc_pkg::OFS_PHY2 |-> cfg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // RULE11
    else $error("unmapped read returned nonzero");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (rst)
      !cfg_rvalid |-> cfg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RULE11
    else $error("read data nonzero outside a read answer");

  c_boundary: cover property (@(posedge clk_sys) pkt_boundary
    && mode != applied);
  c_loader: cover property (@(posedge clk_sys) ld_wr && cfg_wr);
  c_read: cover property (@(posedge clk_sys) cfg_rvalid);
  c_strap: cover property (@(posedge clk_sys) IS_DOWNSTREAM
    && strap_done && rx_pol_inv_dis);
  c_thr_max: cover property (@(posedge clk_sys) cut_thr_code
    == 2'h3);
endmodule : sfmc_top

// *** bench/sfmc_top_test.sv ***
// Self-checking bench for the forwarding-mode register, both port flavours.
// Assumes the rtl/ sources are compiled first; strap held high throughout.
`timescale 1ns/1ps
module sfmc_top_test;
  logic        clk_sys      = 1'b0;
  logic        rst          = 1'b1;
  logic        cfg_wr       = 1'b0;
  logic        cfg_rd       = 1'b0;
  logic [7:0]  cfg_addr     = 8'h00;
  logic [3:0]  cfg_be       = 4'h0;
  logic [31:0] cfg_wdata    = 32'h0000_0000;
  logic        ld_wr        = 1'b0;
  logic [7:0]  ld_addr      = 8'h00;
  logic [31:0] ld_wdata     = 32'h0000_0000;
  logic        strap        = 1'b1;
  logic        pkt_boundary = 1'b0;
  logic [31:0] rd_up;
  logic [31:0] rd_dn;
  logic        rv_up;
  logic        rv_dn;
  logic        store_fwd_mode;
  logic [1:0]  cut_thr_code;
  logic        arb_hold_mode;
  logic        credit_all_types;
  logic        order_egress;
  logic        order_tag;
  logic [5:0]  pm_param;
  logic [6:0]  mode;
  logic        pol_up;
  logic        pol_dn;
  int          fail_count   = 0;
  int          num_checks   = 0;

  assign mode = {order_tag, order_egress, credit_all_types, arb_hold_mode,
                 cut_thr_code, store_fwd_mode};

  always #5 clk_sys = ~clk_sys;

  sfmc_top #(.IS_DOWNSTREAM(1'b0)) i_sfmc_top (
    .clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata(rd_up), .cfg_rvalid(rv_up), .ld_wr, .ld_addr, .ld_wdata,
    .rx_polarity_flip_off_strap(strap), .pkt_boundary, .store_fwd_mode,
    .cut_thr_code, .arb_hold_mode, .credit_all_types, .order_egress,
    .order_tag, .pm_param, .rx_pol_inv_dis(pol_up));

  sfmc_top #(.IS_DOWNSTREAM(1'b1)) i_sfmc_top_dn (
    .clk_sys, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata(rd_dn), .cfg_rvalid(rv_dn), .ld_wr, .ld_addr, .ld_wdata,
    .rx_polarity_flip_off_strap(strap), .pkt_boundary, .store_fwd_mode(),
    .cut_thr_code(), .arb_hold_mode(), .credit_all_types(),
    .order_egress(), .order_tag(), .pm_param(), .rx_pol_inv_dis(pol_dn));

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk_sys);
    #1 cfg_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : wr

  // Read both flavours at once; answer lands one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] eu,
                    input logic [31:0] ed);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk_sys);
    #1 cfg_rd = 1'b0;
    chk("rvalid", 32'h0000_0003, {30'h0, rv_dn, rv_up});
    chk("rdata up", eu, rd_up);
    chk("rdata dn", ed, rd_dn);
    @(posedge clk_sys);
    #1;
  endtask : rd

  task automatic bnd();
    pkt_boundary = 1'b1;
    @(posedge clk_sys);
    #1 pkt_boundary = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : bnd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    #20000;
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rd(8'h74, 32'h0A73_0102, 32'h0A73_4100);
    chk("pol reset", 32'h0000_0002, {30'h0, pol_dn, pol_up});
    chk("mode reset", 32'h0000_0002, {25'h0, mode});
    rd(8'h78, 32'h0000_0080, 32'h0000_0080);
    rd(8'h10, 32'h0000_0000, 32'h0000_0000);
    $display("test reset done");
    wr(8'h74, 4'hF, 32'hFFFF_FFFF);
    wr(8'h78, 4'hF, 32'hFFFF_FFFF);
    rd(8'h74, 32'h0A73_3F7F, 32'h0A73_7F00);
    chk("pol ro", 32'h0000_0002, {30'h0, pol_dn, pol_up});
    rd(8'h78, 32'h0000_0080, 32'h0000_0080);
    chk("mode held", 32'h0000_0002, {25'h0, mode});
    bnd();
    chk("mode all", 32'h0000_007F, {25'h0, mode});
    chk("pm param", 32'h0000_003F, {26'h0, pm_param});
    wr(8'h74, 4'h1, 32'h0000_0000);
    rd(8'h74, 32'h0A73_3F00, 32'h0A73_7F00);
    $display("test write done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h74, 4'hF, 32'(c) << 1);
      bnd();
      chk("thr code", 32'(c) << 1, {25'h0, mode});
    end
    chk("arb clear", 32'h0000_0000, {31'h0, arb_hold_mode});
    $display("test threshold done");
    ld_wr = 1'b1;
    ld_addr = 8'h74;
    ld_wdata = 32'hFFFF_FFFF;
    @(posedge clk_sys);
    #1 ld_wr = 1'b0;
    rd(8'h74, 32'h7FFF_FF7F, 32'h7FFF_FF00);
    chk("pol load", 32'h0000_0003, {30'h0, pol_dn, pol_up});
    bnd();
    chk("mode load", 32'h0000_007F, {25'h0, mode});
    $display("test loader done");
    end_sim();
  end
endmodule : sfmc_top_test
